/* core/occ_regs_pkg.sv */
// constants, types and register map of the overcurrent threshold bank
package occ_regs_pkg;
    localparam int DW = 16;
    localparam int AW = 8;
    // register offsets
    localparam logic [AW-1:0] OFF_CFG    = 8'hc7;
    localparam logic [AW-1:0] OFF_HIGH   = 8'hc8;
    localparam logic [AW-1:0] OFF_LOW    = 8'hc9;
    localparam logic [AW-1:0] OFF_SPA    = 8'hca;
    localparam logic [AW-1:0] OFF_SPB    = 8'hcb;
    localparam logic [AW-1:0] OFF_SPC    = 8'hcc;
    localparam logic [AW-1:0] OFF_SPD    = 8'hcd;
    localparam logic [AW-1:0] OFF_SPE    = 8'hce;
    localparam logic [AW-1:0] OFF_STAT   = 8'hd8;
    localparam logic [AW-1:0] OFF_MASK   = 8'hd9;
    // reset values
    localparam logic [DW-1:0] RST_HIGH   = 16'h7fff;
    localparam logic [DW-1:0] RST_LOW    = 16'h8000;
    localparam logic [DW-1:0] RST_SPA    = 16'h5555;
    localparam logic [DW-1:0] RST_SPB    = 16'h0010;
    localparam logic [DW-1:0] RST_ZERO   = 16'h0000;
    // writable-bit masks of the config and spare words
    localparam logic [DW-1:0] MSK_CFG    = 16'hff00;
    localparam logic [DW-1:0] MSK_SPB    = 16'h07f0;
    localparam logic [DW-1:0] MSK_SPC    = 16'hc703;
    localparam logic [DW-1:0] MSK_SPD    = 16'h00ff;
    localparam logic [DW-1:0] MSK_ALL    = 16'hffff;
    // full-scale disable codes
    localparam logic [DW-1:0] POS_FS     = 16'h7fff;
    localparam logic [DW-1:0] NEG_FS     = 16'h8000;
    // configuration word fields
    localparam int CFG_EN_BIT  = 15;
    localparam int CFG_POL_BIT = 14;
    localparam int CFG_NUM_LO  = 8;
    localparam int NUM_W       = 5;
    localparam int CNT_W       = 8;
    // status bits
    localparam int ST_HT = 0;
    localparam int ST_LT = 1;
    localparam int ST_W  = 2;
    // filter figures
    localparam int FAST_OSR    = 64;
    localparam int OSR_W       = 6;
    // register bus request
    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } bus_req_t;
endpackage

/* core/deglitch_counter.sv */
// per-side consecutive-exceed counter with programmable trip length
`timescale 1ns/1ns
module deglitch_counter (
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    input  wire logic                           run,       // comparator active
    input  wire logic                           sample,    // new filter output
    input  wire logic                           exceed,    // this sample is outside
    input  wire logic [occ_regs_pkg::NUM_W-1:0] numSel,    // count selection
    output logic                                trip       // trip level
);
    import occ_regs_pkg::*;

    logic [CNT_W-1:0] cnt_q;      // consecutive exceeds seen
    logic [CNT_W-1:0] need;       // exceeds needed to trip
    logic [CNT_W-1:0] cntSat;     // next count, saturated

    // map of selection code to consecutive count
    always_comb begin
        unique case (numSel)
            5'h00: need = 8'h01;  5'h01: need = 8'h02;
            5'h02: need = 8'h03;  5'h03: need = 8'h04;
            5'h04: need = 8'h05;  5'h05: need = 8'h06;
            5'h06: need = 8'h07;  5'h07: need = 8'h08;
            5'h08: need = 8'h09;  5'h09: need = 8'h0a;
            5'h0a: need = 8'h0c;  5'h0b: need = 8'h0e;
            5'h0c: need = 8'h10;  5'h0d: need = 8'h12;
            5'h0e: need = 8'h14;  5'h0f: need = 8'h16;
            5'h10: need = 8'h18;  5'h11: need = 8'h1c;
            5'h12: need = 8'h20;  5'h13: need = 8'h28;
            5'h14: need = 8'h30;  5'h15: need = 8'h38;
            5'h16: need = 8'h40;  5'h17: need = 8'h48;
            5'h18: need = 8'h50;  5'h19: need = 8'h58;
            5'h1a: need = 8'h60;  5'h1b: need = 8'h68;
            5'h1c: need = 8'h70;  5'h1d: need = 8'h78;
            5'h1e: need = 8'h7c;  5'h1f: need = 8'h80;
        endcase
    end

    // saturate at the trip length; a shorter length chosen mid-run trips at once
    assign cntSat = (cnt_q >= need) ? need : cnt_q + 8'h01;
    assign trip   = run && (cnt_q >= need);

    // count consecutive exceeds, restart on any sample inside
    always_ff @(posedge clk) begin
        if (!reset_n || !run) begin
            cnt_q <= '0;
        end else if (sample) begin
            cnt_q <= exceed ? cntSat : '0;
        end
    end

    tripAfterCount_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(trip) |-> $past(sample && exceed) || $changed(numSel))
        else $error("trip without an exceeding sample");
    restartInside_a: assert property (@(posedge clk) disable iff (!reset_n)
        sample && !exceed |=> !trip) else $error("count not restarted");
endmodule

/* core/overcurrent_threshold_regs.sv */
// threshold and spare register bank with fast overcurrent comparator
`timescale 1ns/1ns
module overcurrent_threshold_regs (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire occ_regs_pkg::bus_req_t        busReq,        // register request
    output logic [occ_regs_pkg::DW-1:0]        rdata,         // read data, next cycle
    input  wire logic                          converterEn,   // converter b enabled
    input  wire logic                          modBit,        // modulator bitstream
    input  wire logic                          modValid,      // one pulse per mod sample
    output logic [occ_regs_pkg::DW-1:0]        fastResult,    // latest fast filter out
    output logic                               fastValid,     // new result pulse
    output logic                               highTripEventN,// high trip, active low
    output logic                               lowTripEventN, // low trip, active low
    output logic                               faultOut,      // fault pin level
    output logic                               irq            // interrupt level
);
    import occ_regs_pkg::*;

    // register storage
    logic [DW-1:0] cfg_q;      // enable, polarity, count select
    logic [DW-1:0] high_q;     // high trip level
    logic [DW-1:0] low_q;      // low trip level
    logic [DW-1:0] spa_q;      // spare words, stored only with no effect
    logic [DW-1:0] spb_q;
    logic [DW-1:0] spc_q;
    logic [DW-1:0] spd_q;
    logic [DW-1:0] spe_q;
    logic [ST_W-1:0] stat_q;   // sticky event flags
    logic [ST_W-1:0] mask_q;   // interrupt enables
    logic [DW-1:0] rdata_q;    // registered read data
    logic [DW-1:0] rdMux;      // read selection

    // bus decode
    wire wrCfg  = busReq.wr && busReq.addr == OFF_CFG;
    wire wrHigh = busReq.wr && busReq.addr == OFF_HIGH;
    wire wrLow  = busReq.wr && busReq.addr == OFF_LOW;
    wire wrSpa  = busReq.wr && busReq.addr == OFF_SPA;
    wire wrSpb  = busReq.wr && busReq.addr == OFF_SPB;
    wire wrSpc  = busReq.wr && busReq.addr == OFF_SPC;
    wire wrSpd  = busReq.wr && busReq.addr == OFF_SPD;
    wire wrSpe  = busReq.wr && busReq.addr == OFF_SPE;
    wire wrStat = busReq.wr && busReq.addr == OFF_STAT;
    wire wrMask = busReq.wr && busReq.addr == OFF_MASK;

    // configuration fields
    wire              cmpEnable = cfg_q[CFG_EN_BIT];
    wire              polHigh   = cfg_q[CFG_POL_BIT];
    wire [NUM_W-1:0]  numSel    = cfg_q[CFG_NUM_LO +: NUM_W];
    wire              run       = cmpEnable && converterEn;

    // threshold and config writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_q  <= RST_ZERO;
            high_q <= RST_HIGH;
            low_q  <= RST_LOW;
        end else begin
            if (wrCfg)  cfg_q  <= busReq.wdata & MSK_CFG;
            if (wrHigh) high_q <= busReq.wdata;
            if (wrLow)  low_q  <= busReq.wdata;
        end
    end

    // spare words: stored only, no effect on behaviour
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            spa_q <= RST_SPA;
            spb_q <= RST_SPB;
            spc_q <= RST_ZERO;
            spd_q <= RST_ZERO;
            spe_q <= RST_ZERO;
        end else begin
            if (wrSpa) spa_q <= busReq.wdata & MSK_ALL;
            if (wrSpb) spb_q <= busReq.wdata & MSK_SPB;
            if (wrSpc) spc_q <= busReq.wdata & MSK_SPC;
            if (wrSpd) spd_q <= busReq.wdata & MSK_SPD;
            if (wrSpe) spe_q <= busReq.wdata & MSK_ALL;
        end
    end

    // read selection, unmapped reads return zero
    always_comb begin
        unique case (busReq.addr)
            OFF_CFG:  rdMux = cfg_q;
            OFF_HIGH: rdMux = high_q;
            OFF_LOW:  rdMux = low_q;
            OFF_SPA:  rdMux = spa_q;
            OFF_SPB:  rdMux = spb_q;
            OFF_SPC:  rdMux = spc_q;
            OFF_SPD:  rdMux = spd_q;
            OFF_SPE:  rdMux = spe_q;
            OFF_STAT: rdMux = {{(DW-ST_W){1'b0}}, stat_q};
            OFF_MASK: rdMux = {{(DW-ST_W){1'b0}}, mask_q};
            default:  rdMux = RST_ZERO;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!reset_n) rdata_q <= RST_ZERO;
        else          rdata_q <= busReq.rd ? rdMux : RST_ZERO;
    end
    assign rdata = rdata_q;

    // fast path: sinc3 decimator, fixed ratio 64
    logic [DW+2:0] int1_q, int2_q, int3_q;   // integrators
    logic [DW+2:0] dif1_q, dif2_q, dif3_q;   // comb delays
    logic [DW+2:0] c1, c2, c3;               // comb stages
    logic [OSR_W-1:0] phase_q;               // decimation phase
    logic [DW-1:0] result_q;                 // decimated result
    logic          valid_q;                  // result strobe
    logic          bitInt;                   // synchronised bitstream
    logic [1:0]    bitSync_q;                // pin synchroniser
    logic [1:0]    vldSync_q;                // strobe synchroniser
    logic          vldPrev_q;                // strobe edge store

    // bring the modulator pins into the clock domain
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bitSync_q <= '0;
            vldSync_q <= '0;
            vldPrev_q <= 1'b0;
        end else begin
            bitSync_q <= {bitSync_q[0], modBit};
            vldSync_q <= {vldSync_q[0], modValid};
            vldPrev_q <= vldSync_q[1];
        end
    end
    assign bitInt = bitSync_q[1];
    wire modTick  = vldSync_q[1] && !vldPrev_q;
    wire decTick  = modTick && phase_q == OSR_W'(FAST_OSR - 1);
    wire [DW+2:0] inSample = bitInt ? 19'h00001 : 19'h7ffff;

    // integrator chain runs at modulator rate
    always_ff @(posedge clk) begin
        if (!reset_n || !run) begin
            int1_q  <= '0;
            int2_q  <= '0;
            int3_q  <= '0;
            phase_q <= '0;
        end else if (modTick) begin
            int1_q  <= int1_q + inSample;
            int2_q  <= int2_q + int1_q;
            int3_q  <= int3_q + int2_q;
            phase_q <= phase_q + 6'h01;
        end
    end

    assign c1 = int3_q - dif1_q;
    assign c2 = c1 - dif2_q;
    assign c3 = c2 - dif3_q;

    // comb chain runs at output rate
    always_ff @(posedge clk) begin
        if (!reset_n || !run) begin
            dif1_q   <= '0;
            dif2_q   <= '0;
            dif3_q   <= '0;
            result_q <= RST_ZERO;
            valid_q  <= 1'b0;
        end else begin
            valid_q <= decTick;
            if (decTick) begin
                dif1_q   <= int3_q;
                dif2_q   <= c1;
                dif3_q   <= c2;
                result_q <= c3[DW+2:3];   // keep 16 msb of 19-bit span
            end
        end
    end
    assign fastResult = result_q;
    assign fastValid  = valid_q;

    // signed compare, full scale codes disable a side
    wire highOn  = high_q != POS_FS;
    wire lowOn   = low_q != NEG_FS;
    wire aboveHi = highOn && ($signed(result_q) > $signed(high_q));
    wire belowLo = lowOn && ($signed(result_q) < $signed(low_q));
    logic htTrip;
    logic ltTrip;
    // a side at its full-scale code stops counting at once, so no trip stands
    wire  highRun = run && highOn;
    wire  lowRun  = run && lowOn;

    // both sides count independently on every result
    deglitch_counter highCnt (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (highRun),
        .sample  (valid_q),
        .exceed  (aboveHi),
        .numSel  (numSel),
        .trip    (htTrip)
    );
    deglitch_counter lowCnt (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (lowRun),
        .sample  (valid_q),
        .exceed  (belowLo),
        .numSel  (numSel),
        .trip    (ltTrip)
    );

    assign highTripEventN = !htTrip;
    assign lowTripEventN  = !ltTrip;
    wire   faultActive    = htTrip || ltTrip;
    assign faultOut       = polHigh ? faultActive : !faultActive;

    // sticky flags, set wins over write-one-to-clear
    wire [ST_W-1:0] evSet = {ltTrip, htTrip};
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            stat_q <= (stat_q & ~(wrStat ? busReq.wdata[ST_W-1:0] : 2'b00)) | evSet;
            if (wrMask) mask_q <= busReq.wdata[ST_W-1:0];
        end
    end
    assign irq = |(stat_q & mask_q);

    // checks
    highDisabled_a: assert property (@(posedge clk) disable iff (!reset_n)
        high_q == POS_FS |-> highTripEventN) else $error("high trip while disabled");
    lowDisabled_a: assert property (@(posedge clk) disable iff (!reset_n)
        low_q == NEG_FS |-> lowTripEventN) else $error("low trip while disabled");
    faultPolarity_a: assert property (@(posedge clk) disable iff (!reset_n)
        faultOut == (polHigh ~^ (!highTripEventN || !lowTripEventN)))
        else $error("fault pin level wrong");
    runGate_a: assert property (@(posedge clk) disable iff (!reset_n)
        !run |=> ##1 (highTripEventN && lowTripEventN)) else $error("trip while off");
    highWrite_a: assert property (@(posedge clk) disable iff (!reset_n)
        wrHigh |=> high_q == $past(busReq.wdata)) else $error("high level write lost");
    lowReset_a: assert property (@(posedge clk)
        !reset_n |=> low_q == RST_LOW) else $error("low level reset wrong");
    spareReset_a: assert property (@(posedge clk)
        !reset_n |=> spa_q == RST_SPA && spb_q == RST_SPB) else $error("spare reset wrong");
    spareMask_a: assert property (@(posedge clk) disable iff (!reset_n)
        (spb_q & ~MSK_SPB) == RST_ZERO) else $error("spare b reserved bits set");
    highCompare_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(highTripEventN) |-> $past(valid_q && aboveHi))
        else $error("high trip without exceed");
    lowCompare_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(lowTripEventN) |-> $past(valid_q && belowLo))
        else $error("low trip without exceed");
    stickySet_a: assert property (@(posedge clk) disable iff (!reset_n)
        !highTripEventN |=> stat_q[ST_HT]) else $error("high flag not set");

    highTripSeen_c: cover property (@(posedge clk) disable iff (!reset_n) !highTripEventN);
    lowTripSeen_c: cover property (@(posedge clk) disable iff (!reset_n) !lowTripEventN);
    irqSeen_c: cover property (@(posedge clk) disable iff (!reset_n) irq);
    spareWrite_c: cover property (@(posedge clk) disable iff (!reset_n) wrSpb);
endmodule

/* tb/test_overcurrent_threshold_regs.sv */
// self-checking bench for the threshold register bank and fast comparator
`timescale 1ns/1ns
module test_overcurrent_threshold_regs;
    import occ_regs_pkg::*;
    logic                clk;            // bench clock
    logic                reset_n;        // synchronous reset, active low
    bus_req_t            busReq;         // register request
    logic [DW-1:0]       rdata;          // read data
    logic                converterEn;    // converter b enable
    logic                modBit;         // modulator bitstream
    logic                modValid;       // modulator strobe
    logic [DW-1:0]       fastResult;     // fast filter output
    logic                fastValid;      // fast filter result pulse
    logic                highTripEventN; // high trip, active low
    logic                lowTripEventN;  // low trip, active low
    logic                faultOut;       // fault pin
    logic                irq;            // interrupt level
    int                  miscompares;    // mismatch count
    int                  cmp_count;      // comparison count
    int                  density;        // ones out of every four mod samples
    int                  runCnt;         // consecutive results above hiTh
    logic [1:0]          phase;          // strobe phase
    logic [1:0]          sampIdx;        // position inside four-sample pattern
    logic                prevHt;         // high trip one cycle ago
    logic                checkRun;       // enables the deglitch count check
    logic [DW-1:0]       hiTh;           // bench copy of the high threshold
    logic [DW-1:0]       got;            // read result
    // map offsets and their reset values, config through mask
    localparam logic [AW-1:0] RegAddr [10] = '{OFF_CFG, OFF_HIGH, OFF_LOW, OFF_SPA,
        OFF_SPB, OFF_SPC, OFF_SPD, OFF_SPE, OFF_STAT, OFF_MASK};
    localparam logic [DW-1:0] RstVal [10] = '{16'h0000, 16'h7fff, 16'h8000, 16'h5555,
        16'h0010, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    // readable masks of the data words c8 through ce
    localparam logic [DW-1:0] RwMask [7] = '{16'hffff, 16'hffff, 16'hffff, 16'h07f0,
        16'hc703, 16'h00ff, 16'hffff};

    overcurrent_threshold_regs DUT (
        .clk            (clk),
        .reset_n        (reset_n),
        .busReq         (busReq),
        .rdata          (rdata),
        .converterEn    (converterEn),
        .modBit         (modBit),
        .modValid       (modValid),
        .fastResult     (fastResult),
        .fastValid      (fastValid),
        .highTripEventN (highTripEventN),
        .lowTripEventN  (lowTripEventN),
        .faultOut       (faultOut),
        .irq            (irq)
    );

    // free-running 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // modulator source: one sample every four cycles, density ones per four
    always @(posedge clk) begin
        phase    <= phase + 2'd1;
        modValid <= phase[1];
        if (phase == 2'd1) begin
            modBit  <= (int'(sampIdx) < density);
            sampIdx <= sampIdx + 2'd1;
        end
    end

    // deglitch monitor: count consecutive exceeding results, check at trip onset
    always @(posedge clk) begin
        if (fastValid)
            runCnt <= ($signed(fastResult) > $signed(hiTh)) ? runCnt + 1 : 0;
        prevHt <= highTripEventN;
        if (checkRun && prevHt === 1'b1 && highTripEventN === 1'b0)
            check(runCnt[DW-1:0], 16'h0004, "deglitch count");
    end

    // compare one value and count it
    task automatic check(input logic [DW-1:0] g, input logic [DW-1:0] e, input string what);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask

    // one-cycle write
    task automatic wrReg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask

    // one-cycle read, data taken in the cycle after the strobe
    task automatic rdReg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        busReq.rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    // wait for n filter results under a bound
    task automatic waitResults(input int n);
        int seen;
        seen = 0;
        for (int i = 0; i < n * 300 && seen < n; i++) begin
            @(posedge clk);
            if (fastValid === 1'b1) seen++;
        end
    endtask

    // wait for a trip output to go active, bounded
    task automatic waitTrip(input bit hiSide);
        for (int i = 0; i < 20000; i++) begin
            @(posedge clk);
            if ((hiSide ? highTripEventN : lowTripEventN) === 1'b0) break;
        end
    endtask

    // verdict and end of run
    task automatic complete_run();
        $display("miscompares=%0d comparisons=%0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog cuts a hang short
    initial begin
        #500000;
        miscompares++;
        complete_run();
    end

    // main sequence
    initial begin
        reset_n = 1'b0; busReq = '0; converterEn = 1'b0; modBit = 1'b0; modValid = 1'b0;
        phase = 2'd0; sampIdx = 2'd0; density = 2; runCnt = 0; prevHt = 1'b1;
        checkRun = 1'b0; hiTh = 16'h7fff; miscompares = 0; cmp_count = 0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        // reset values and an unmapped offset
        for (int i = 0; i < 10; i++) begin
            rdReg(RegAddr[i], got);
            check(got, RstVal[i], "reset value");
        end
        wrReg(8'h10, 16'hffff);
        rdReg(8'h10, got);
        check(got, 16'h0000, "unmapped offset");
        // all ones then all zeros through every data word, reserved bits read zero
        for (int i = 0; i < 7; i++) begin
            wrReg(OFF_HIGH + 8'(i), 16'hffff);
            rdReg(OFF_HIGH + 8'(i), got);
            check(got, RwMask[i], "write ones");
            wrReg(OFF_HIGH + 8'(i), 16'h0000);
            rdReg(OFF_HIGH + 8'(i), got);
            check(got, 16'h0000, "write zeros");
        end
        wrReg(OFF_LOW, NEG_FS);
        // high trip after four consecutive results, fault active low
        hiTh = 16'h1000;
        wrReg(OFF_HIGH, hiTh);
        wrReg(OFF_CFG, 16'h8300);
        density = 3;
        checkRun = 1'b1;
        converterEn <= 1'b1;
        waitTrip(1'b1);
        check({15'h0, highTripEventN}, 16'h0000, "high trip");
        check({15'h0, lowTripEventN}, 16'h0001, "low side idle");
        check({15'h0, faultOut}, 16'h0000, "fault low");
        check(fastResult, 16'h4000, "filter step");
        repeat (3) @(posedge clk);
        checkRun = 1'b0;
        rdReg(OFF_STAT, got);
        check(got, 16'h0001, "status high");
        check({15'h0, irq}, 16'h0000, "masked irq");
        wrReg(OFF_MASK, 16'h0001);
        repeat (2) @(posedge clk);
        check({15'h0, irq}, 16'h0001, "unmasked irq");
        // polarity flip while tripped
        wrReg(OFF_CFG, 16'hc300);
        repeat (2) @(posedge clk);
        check({15'h0, faultOut}, 16'h0001, "fault high");
        // full scale switches the high side off
        hiTh = POS_FS;
        wrReg(OFF_HIGH, POS_FS);
        waitResults(4);
        check({15'h0, highTripEventN}, 16'h0001, "high disabled");
        check({15'h0, faultOut}, 16'h0000, "no fault");
        wrReg(OFF_STAT, 16'h0003);
        rdReg(OFF_STAT, got);
        check(got, 16'h0000, "status cleared");
        check({15'h0, irq}, 16'h0000, "irq cleared");
        // low trip, then full-scale disable at a result of exactly negative full scale
        wrReg(OFF_LOW, 16'hf000);
        density = 1;
        waitTrip(1'b0);
        check({15'h0, lowTripEventN}, 16'h0000, "low trip");
        check({15'h0, faultOut}, 16'h0001, "fault on low");
        wrReg(OFF_LOW, NEG_FS);
        density = 0;
        waitResults(5);
        check({15'h0, lowTripEventN}, 16'h0001, "low disabled");
        // converter off stops the comparator
        converterEn <= 1'b0;
        wrReg(OFF_LOW, 16'hf000);
        repeat (2000) @(posedge clk);
        check({15'h0, lowTripEventN}, 16'h0001, "converter off");
        check({15'h0, fastValid}, 16'h0000, "filter stopped");
        complete_run();
    end
endmodule
